// >>> core/bridge_option_config.v
`timescale 1ns/1ns
// How it works
// - The third general pin as interrupt input fires by edge or level, default level-high.
// - A level interrupt fires only after the level lasts 1, 5 or 30 ms.
// - With power saving on, five idle seconds request the 30 kHz system clock.
// - In USB suspend each pin keeps function, floats, drives low or drives high.
// - Target I2C address is held; zero means no target is attached.
// - Descriptor start address for the target is held, default zero.
// - Target interrupt line is sensed by the configured trigger, default rising edge.
// - Optional idle, protocol and power requests each have a support flag, default off.
// - HID subclass is none or boot interface, default none.
// - HID protocol code is none, keyboard or mouse, default none.
// - Charger detect output shows detection with configured polarity, default active-high.
// - Charger detection on its output can be disabled, default enabled.
// - Weak pulls on the six general pins are enabled by option, default off.
// - A present external memory image overrides the built-in defaults.
`include "bridge_option_consts.vh"
module bridge_option_config #(
  parameter IDLE_CYCLES = `IDLE_SECONDS * `CLOCK_HZ,
  parameter MS_CYCLES = `CLOCK_HZ / 1000
) (
  input wire CLOCK,
  input wire NRST,
  input wire CLOCK_ENABLE,
  input wire MEMORY_PRESENT,
  input wire MEMORY_VALID,
  input wire [`CFG_WIDTH-1:0] MEMORY_IMAGE,
  input wire MEMORY_PULL_ENABLE,
  input wire INTERRUPT_FUNCTION_SELECT,
  input wire GENERAL_IO_PIN_THREE,
  input wire TARGET_INTERRUPT_LINE,
  input wire CHARGER_DETECTED,
  input wire BUSY,
  input wire USB_SUSPEND,
  input wire [5:0] PIN_FUNCTION_OUT,
  input wire [5:0] PIN_FUNCTION_OE,
  output reg CONFIG_READY,
  output reg HOST_INTERRUPT_WAKE,
  output reg TARGET_INTERRUPT,
  output reg SLOW_CLOCK_REQUEST,
  output reg [5:0] PIN_OUT,
  output reg [5:0] PIN_OE,
  output reg PULL_ENABLE,
  output reg CHARGER_DETECT_OUT,
  output reg TARGET_ATTACHED,
  output reg [6:0] TARGET_ADDRESS,
  output reg [15:0] DESCRIPTOR_ADDRESS,
  output reg SUPPORT_IDLE,
  output reg SUPPORT_PROTOCOL,
  output reg SUPPORT_POWER,
  output reg BOOT_SUBCLASS,
  output reg [1:0] PROTOCOL_CODE
);
  localparam [31:0] C1 = `WIDTH_1MS_MS * MS_CYCLES;
  localparam [31:0] C5 = `WIDTH_5MS_MS * MS_CYCLES;
  localparam [31:0] C30 = `WIDTH_30MS_MS * MS_CYCLES;
  localparam [31:0] IDLE_LIMIT = IDLE_CYCLES;
  localparam ST_WAIT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [1:0] settle;
  reg [`CFG_WIDTH-1:0] cfg;
  reg pull_cfg;
  reg [1:0] sync_pin;
  reg [1:0] sync_tgt;
  reg [1:0] sync_chg;
  reg [1:0] sync_pres;
  reg [1:0] sync_valid;
  reg last_pin;
  reg last_tgt;
  reg [31:0] level_count;
  reg [31:0] idle_count;

  wire [1:0] int_trig = cfg[`CFG_INT_TRIG_LSB+1:`CFG_INT_TRIG_LSB];
  wire [1:0] int_width = cfg[`CFG_INT_WIDTH_LSB+1:`CFG_INT_WIDTH_LSB];
  wire [1:0] tgt_trig = cfg[`CFG_HID_TRIG_LSB+1:`CFG_HID_TRIG_LSB];
  wire [1:0] susp_mode = cfg[`CFG_SUSP_LSB+1:`CFG_SUSP_LSB];
  wire [31:0] width_limit = (int_width == `WIDTH_1MS) ? C1 :
    (int_width == `WIDTH_5MS) ? C5 : C30;
  wire is_level = int_trig[1];
  wire pin_active = (int_trig == `TRIG_HIGH) ? sync_pin[1] : ~sync_pin[1];

  // Shared trigger decode for both interrupt sources.
  function edge_hit;
    input [1:0] trig;
    input now;
    input prev;
    begin
      case (trig)
        `TRIG_RISE: edge_hit = now & ~prev;
        `TRIG_FALL: edge_hit = ~now & prev;
        `TRIG_HIGH: edge_hit = now;
        default: edge_hit = ~now;
      endcase
    end
  endfunction

  always @(posedge CLOCK) begin
    if (!NRST) begin
      sync_pin <= 2'h0;
      sync_tgt <= 2'h0;
      sync_chg <= 2'h0;
      sync_pres <= 2'h0;
      sync_valid <= 2'h0;
    end else if (CLOCK_ENABLE) begin
      sync_pin <= {sync_pin[0], GENERAL_IO_PIN_THREE};
      sync_tgt <= {sync_tgt[0], TARGET_INTERRUPT_LINE};
      sync_chg <= {sync_chg[0], CHARGER_DETECTED};
      sync_pres <= {sync_pres[0], MEMORY_PRESENT};
      sync_valid <= {sync_valid[0], MEMORY_VALID};
    end
  end

  // The image is sampled once; later changes on the memory port are ignored until reset.
  always @(posedge CLOCK) begin
    if (!NRST) begin
      state <= ST_WAIT;
      settle <= 2'h0;
      cfg <= `CFG_DEFAULT;
      pull_cfg <= `CFG_PULL_DEFAULT;
      CONFIG_READY <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      case (state)
        ST_WAIT: begin
          // Deciding on the reset value of the synchronisers would lose a fitted memory.
          if (settle != `SYNC_STAGES) begin
            settle <= settle + 2'h1;
          end else if (!sync_pres[1]) begin
            state <= ST_RUN;
            CONFIG_READY <= 1'b1;
          end else if (sync_valid[1]) begin
            cfg <= MEMORY_IMAGE;
            pull_cfg <= MEMORY_PULL_ENABLE;
            state <= ST_RUN;
            CONFIG_READY <= 1'b1;
          end
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_WAIT;
      endcase
    end
  end

  wire run = CONFIG_READY;

  always @(posedge CLOCK) begin
    if (!NRST) begin
      last_pin <= 1'b0;
      last_tgt <= 1'b0;
      level_count <= 32'h0;
      HOST_INTERRUPT_WAKE <= 1'b0;
      TARGET_INTERRUPT <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      last_pin <= sync_pin[1];
      last_tgt <= sync_tgt[1];
      if (!run || !INTERRUPT_FUNCTION_SELECT || !is_level || !pin_active) begin
        level_count <= 32'h0;
      end else if (level_count <= width_limit) begin
        level_count <= level_count + 32'h1;
      end
      if (!run || !INTERRUPT_FUNCTION_SELECT) begin
        HOST_INTERRUPT_WAKE <= 1'b0;
      end else if (is_level) begin
        HOST_INTERRUPT_WAKE <= pin_active && (level_count >= width_limit);
      end else begin
        HOST_INTERRUPT_WAKE <= edge_hit(int_trig, sync_pin[1], last_pin);
      end
      TARGET_INTERRUPT <= run && TARGET_ATTACHED &&
        edge_hit(tgt_trig, sync_tgt[1], last_tgt);
    end
  end

  // Any activity restarts the idle count, so a burst of traffic never lets the clock drop.
  always @(posedge CLOCK) begin
    if (!NRST) begin
      idle_count <= 32'h0;
      SLOW_CLOCK_REQUEST <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      if (!run || BUSY || !cfg[`CFG_PWR_SAVE_BIT]) begin
        idle_count <= 32'h0;
        SLOW_CLOCK_REQUEST <= 1'b0;
      end else if (idle_count >= IDLE_LIMIT - 32'h1) begin
        SLOW_CLOCK_REQUEST <= 1'b1;
      end else begin
        idle_count <= idle_count + 32'h1;
      end
    end
  end

  always @(posedge CLOCK) begin
    if (!NRST) begin
      PIN_OUT <= 6'h00;
      PIN_OE <= 6'h00;
      PULL_ENABLE <= 1'b0;
      CHARGER_DETECT_OUT <= 1'b0;
      TARGET_ATTACHED <= 1'b0;
      TARGET_ADDRESS <= 7'h00;
      DESCRIPTOR_ADDRESS <= 16'h0000;
      SUPPORT_IDLE <= 1'b0;
      SUPPORT_PROTOCOL <= 1'b0;
      SUPPORT_POWER <= 1'b0;
      BOOT_SUBCLASS <= 1'b0;
      PROTOCOL_CODE <= `PROTO_NONE;
    end else if (CLOCK_ENABLE) begin
      if (!run) begin
        PIN_OUT <= 6'h00;
        PIN_OE <= 6'h00;
      end else if (USB_SUSPEND && susp_mode != `SUSP_KEEP) begin
        PIN_OUT <= (susp_mode == `SUSP_HIGH) ? 6'h3F : 6'h00;
        PIN_OE <= (susp_mode == `SUSP_TRI) ? 6'h00 : 6'h3F;
      end else begin
        PIN_OUT <= PIN_FUNCTION_OUT;
        PIN_OE <= PIN_FUNCTION_OE;
      end
      PULL_ENABLE <= run & pull_cfg;
      CHARGER_DETECT_OUT <= run ? (cfg[`CFG_CHG_POL_BIT] ^
        (sync_chg[1] & ~cfg[`CFG_CHG_DIS_BIT])) : 1'b0;
      TARGET_ADDRESS <= cfg[`CFG_HID_ADDR_LSB+6:`CFG_HID_ADDR_LSB];
      TARGET_ATTACHED <= run && (cfg[`CFG_HID_ADDR_LSB+6:`CFG_HID_ADDR_LSB] != 7'h00);
      DESCRIPTOR_ADDRESS <= cfg[`CFG_HID_DESC_LSB+15:`CFG_HID_DESC_LSB];
      SUPPORT_IDLE <= cfg[`CFG_OPT_IDLE_BIT];
      SUPPORT_PROTOCOL <= cfg[`CFG_OPT_PROTO_BIT];
      SUPPORT_POWER <= cfg[`CFG_OPT_POWER_BIT];
      BOOT_SUBCLASS <= cfg[`CFG_SUBCLASS_BIT];
      PROTOCOL_CODE <= cfg[`CFG_PROTO_LSB+1:`CFG_PROTO_LSB];
    end
  end
endmodule

// >>> core/bridge_option_consts.vh
`ifndef BRIDGE_OPTION_CONSTS_VH
`define BRIDGE_OPTION_CONSTS_VH
// Trigger type encodings.
`define TRIG_RISE 2'h0
`define TRIG_FALL 2'h1
`define TRIG_HIGH 2'h2
`define TRIG_LOW 2'h3
// Level width select encodings.
`define WIDTH_1MS 2'h0
`define WIDTH_5MS 2'h1
`define WIDTH_30MS 2'h2
// Suspend pin behaviour encodings.
`define SUSP_KEEP 2'h0
`define SUSP_TRI 2'h1
`define SUSP_LOW 2'h2
`define SUSP_HIGH 2'h3
// HID protocol codes.
`define PROTO_NONE 2'h0
`define PROTO_KEYBOARD 2'h1
`define PROTO_MOUSE 2'h2
// Configuration image layout (40 bits).
`define CFG_WIDTH 40
`define CFG_INT_TRIG_LSB 0
`define CFG_INT_WIDTH_LSB 2
`define CFG_PWR_SAVE_BIT 4
`define CFG_SUSP_LSB 5
`define CFG_HID_ADDR_LSB 7
`define CFG_HID_DESC_LSB 14
`define CFG_HID_TRIG_LSB 30
`define CFG_OPT_IDLE_BIT 32
`define CFG_OPT_PROTO_BIT 33
`define CFG_OPT_POWER_BIT 34
`define CFG_SUBCLASS_BIT 35
`define CFG_PROTO_LSB 36
`define CFG_CHG_POL_BIT 38
`define CFG_CHG_DIS_BIT 39
// Built-in defaults: level-high, 30ms, power save on, rising edge for the target.
`define CFG_DEFAULT 40'h000000001A
`define CFG_PULL_DEFAULT 1'h0
// Timing in their own units.
`define CLOCK_HZ 10000000
`define SYNC_STAGES 2'h2
`define IDLE_SECONDS 5
`define WIDTH_1MS_MS 1
`define WIDTH_5MS_MS 5
`define WIDTH_30MS_MS 30
`endif

// >>> verification/bridge_option_config_properties.sv
`timescale 1ns/1ns
module bridge_option_config_properties #(parameter IDLE_CYCLES = 100, MS_CYCLES = 4) (
  input wire CLOCK, NRST, CLOCK_ENABLE, BUSY, USB_SUSPEND, INTERRUPT_FUNCTION_SELECT,
  input wire CONFIG_READY, HOST_INTERRUPT_WAKE, TARGET_INTERRUPT, SLOW_CLOCK_REQUEST,
  input wire PULL_ENABLE, TARGET_ATTACHED, SUPPORT_IDLE, SUPPORT_POWER,
  input wire [1:0] PROTOCOL_CODE,
  input wire [5:0] PIN_FUNCTION_OUT, PIN_FUNCTION_OE, PIN_OUT, PIN_OE,
  input wire [6:0] TARGET_ADDRESS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence select_off;
    !INTERRUPT_FUNCTION_SELECT [*3];
  endsequence
  sequence loaded;
    CONFIG_READY && $past(CONFIG_READY);
  endsequence
  quiet_before_load_a: assert property (!CONFIG_READY |->
    !HOST_INTERRUPT_WAKE && !SLOW_CLOCK_REQUEST && !PIN_OE && !PULL_ENABLE) else $error("early");
  ready_held_a: assert property (CONFIG_READY |=> CONFIG_READY) else $error("ready lost");
  options_frozen_a: assert property (loaded |=>
    $stable({TARGET_ADDRESS, PROTOCOL_CODE, SUPPORT_IDLE, SUPPORT_POWER})) else $error("drift");
  attach_by_addr_a: assert property (loaded |->
    TARGET_ATTACHED == (TARGET_ADDRESS != 7'h00)) else $error("attach flag");
  no_target_irq_a: assert property (TARGET_ADDRESS == 7'h00 |->
    !TARGET_INTERRUPT) else $error("target irq");
  slow_clock_wake_a: assert property (SLOW_CLOCK_REQUEST && BUSY && CLOCK_ENABLE |=>
    !SLOW_CLOCK_REQUEST) else $error("no wake");
  slow_clock_idle_a: assert property ($rose(SLOW_CLOCK_REQUEST) |->
    !$past(BUSY) && CONFIG_READY) else $error("slow early");
  pins_follow_a: assert property (loaded and CLOCK_ENABLE && !USB_SUSPEND |=>
    PIN_OUT == $past(PIN_FUNCTION_OUT) && PIN_OE == $past(PIN_FUNCTION_OE)) else $error("pins");
  irq_needs_select_a: assert property (select_off |->
    !HOST_INTERRUPT_WAKE) else $error("irq unselected");
endmodule

// >>> verification/option_memory_model.sv
`timescale 1ns/1ns
module option_memory_model (
  input wire CLOCK, NRST, fit, pull,
  input wire [3:0] lag,
  input wire [39:0] img,
  output wire MEMORY_PRESENT, MEMORY_VALID, MEMORY_PULL_ENABLE,
  output wire [39:0] MEMORY_IMAGE
);
  reg [3:0] n;
  always @(posedge CLOCK) begin
    if (!NRST) n <= 4'h0;
    else if (n != lag) n <= n + 4'h1;
  end
  // Presence settles before valid rises and the image only with it, so a slow lag tests the wait
  assign MEMORY_PRESENT = fit;
  assign MEMORY_VALID = fit && n == lag;
  // Outside the valid window the lines show the inverse, never a stale image.
  assign MEMORY_IMAGE = MEMORY_VALID ? img : ~img;
  assign MEMORY_PULL_ENABLE = MEMORY_VALID ? pull : ~pull;
endmodule

// >>> verification/bridge_option_config_tb.sv
`timescale 1ns/1ns
`include "bridge_option_consts.vh"
module bridge_option_config_tb;
  reg CLOCK = 0, NRST = 0, CLOCK_ENABLE = 1, BUSY = 1, USB_SUSPEND = 0, fit = 0, pull = 0;
  reg INTERRUPT_FUNCTION_SELECT = 0, GENERAL_IO_PIN_THREE = 0, TARGET_INTERRUPT_LINE = 0;
  reg CHARGER_DETECTED = 0;
  reg [3:0] lag = 1;
  reg [39:0] img = 0, m;
  reg [5:0] PIN_FUNCTION_OUT = 0, PIN_FUNCTION_OE = 0;
  reg [31:0] seed = 37611;
  integer err_total = 0, num_checks = 0, i, t, w, hc, hf, tc, tf;
  wire CONFIG_READY, HOST_INTERRUPT_WAKE, TARGET_INTERRUPT, SLOW_CLOCK_REQUEST, PULL_ENABLE;
  wire CHARGER_DETECT_OUT, TARGET_ATTACHED, SUPPORT_IDLE, SUPPORT_PROTOCOL, SUPPORT_POWER;
  wire BOOT_SUBCLASS, MEMORY_PRESENT, MEMORY_VALID, MEMORY_PULL_ENABLE;
  wire [1:0] PROTOCOL_CODE;
  wire [5:0] PIN_OUT, PIN_OE;
  wire [6:0] TARGET_ADDRESS;
  wire [15:0] DESCRIPTOR_ADDRESS;
  wire [39:0] MEMORY_IMAGE;
  wire [31:0] seen = {CONFIG_READY, TARGET_ATTACHED, TARGET_ADDRESS, DESCRIPTOR_ADDRESS,
    BOOT_SUBCLASS, SUPPORT_POWER, SUPPORT_PROTOCOL, SUPPORT_IDLE, PROTOCOL_CODE, PULL_ENABLE};
  bridge_option_config #(.IDLE_CYCLES(100), .MS_CYCLES(4)) dut_u (.*);
  option_memory_model mem_u (.*);
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] v;
    begin
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  function [31:0] fields(input [39:0] c, input p);
    fields = {1'b1, c[13:7] != 7'h00, c[13:7], c[29:14], c[35:32], c[37:36], p};
  endfunction
  function [11:0] susp(input [1:0] md, input [5:0] o, input [5:0] e);
    case (md)
      `SUSP_KEEP: susp = {o, e};
      `SUSP_TRI: susp = 12'h000;
      `SUSP_LOW: susp = 12'h03F;
      default: susp = 12'hFFF;
    endcase
  endfunction
  task chk(input [8*10:1] what, input [39:0] exp, input [39:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 5; i = i + 1) begin
      @(negedge CLOCK);
      NRST = 0;
      BUSY = 1;
      INTERRUPT_FUNCTION_SELECT = 0;
      @(negedge CLOCK);
      seed = xs(seed);
      img[31:0] = seed;
      seed = xs(seed);
      img[39:32] = seed[7:0];
      lag = {1'b0, seed[10:8]} + 4'h1;
      pull = seed[12];
      // Passes 1 to 4 between them walk every trigger, suspend, width and protocol code.
      img[1:0] = i[1:0];
      img[31:30] = i[1:0];
      img[6:5] = i[1:0];
      img[3:2] = 2'(i % 3);
      img[37:36] = 2'(i % 3);
      if (i == 1) img[13:7] = 7'h00;
      fit = i != 0;
      m = fit ? img : `CFG_DEFAULT;
      @(negedge CLOCK);
      NRST = 1;
      for (t = 0; t < 30 && CONFIG_READY !== 1'b1; t = t + 1) @(negedge CLOCK);
      repeat (2) @(negedge CLOCK);
      chk("fields", fields(m, fit & pull), seen);
      if (i == 0) chk("defaults",
        {`TRIG_HIGH, `WIDTH_30MS, 1'b1, `SUSP_KEEP, `TRIG_RISE},
        {m[1:0], m[3:2], m[4], m[6:5], m[31:30]});
      CHARGER_DETECTED = seed[13];
      PIN_FUNCTION_OUT = seed[19:14] & 6'h37;
      PIN_FUNCTION_OE = seed[25:20] & 6'h37;
      USB_SUSPEND = 1;
      repeat (5) @(negedge CLOCK);
      chk("charger", m[38] ^ (seed[13] & ~m[39]), CHARGER_DETECT_OUT);
      chk("suspend", susp(m[6:5], PIN_FUNCTION_OUT, PIN_FUNCTION_OE),
        {m[6:5] == `SUSP_TRI ? 6'h00 : PIN_OUT, PIN_OE});
      USB_SUSPEND = 0;
      w = 4 * (m[3:2] == `WIDTH_1MS ? 1 : m[3:2] == `WIDTH_5MS ? 5 : 30);
      GENERAL_IO_PIN_THREE = m[0];
      TARGET_INTERRUPT_LINE = m[30];
      INTERRUPT_FUNCTION_SELECT = 1;
      repeat (10) @(negedge CLOCK);
      GENERAL_IO_PIN_THREE = ~m[0];
      TARGET_INTERRUPT_LINE = ~m[30];
      hc = 0;
      tc = 0;
      hf = 999;
      tf = 999;
      for (t = 0; t < 140; t = t + 1) begin
        @(negedge CLOCK);
        hc = hc + (HOST_INTERRUPT_WAKE === 1'b1);
        tc = tc + (TARGET_INTERRUPT === 1'b1);
        if (HOST_INTERRUPT_WAKE === 1'b1 && hf == 999) hf = t;
        if (TARGET_INTERRUPT === 1'b1 && tf == 999) tf = t;
      end
      chk("host irq", 1, m[1] ? hf > w - 3 && hf < w + 7 : hc == 1);
      chk("target irq", m[13:7] != 7'h00, m[31] ? tf < 8 : tc == 1);
      BUSY = 0;
      // Frozen cycles must not count toward the idle span.
      CLOCK_ENABLE = 0;
      repeat (10) @(negedge CLOCK);
      CLOCK_ENABLE = 1;
      for (t = 0; t < 200 && SLOW_CLOCK_REQUEST !== 1'b1; t = t + 1) @(negedge CLOCK);
      chk("idle", m[4], t > 97 && t < 106);
      BUSY = 1;
      repeat (2) @(negedge CLOCK);
      chk("wake", 0, SLOW_CLOCK_REQUEST);
    end
    test_done;
  end
  initial begin
    #(100 * 5000);
    err_total = err_total + 1;
    test_done;
  end
endmodule
bind bridge_option_config bridge_option_config_properties #(.IDLE_CYCLES(IDLE_CYCLES),
  .MS_CYCLES(MS_CYCLES)) prop_u (.*);
